// ---- core/mrr_pkg.sv ----
package mrr_pkg;

  // Bus and register geometry.
  localparam int          APB_AW           = 12;
  localparam int          APB_DW           = 32;
  localparam int          NUM_PAIRS        = 4;
  localparam int          FIELD_W          = 2;

  // Printed register offsets are indices; byte address is four times them.
  localparam logic [11:0] IDX_INIT_CTRL    = 12'h094;
  localparam logic [11:0] IDX_REFRESH_CTRL = 12'h0bf;
  localparam logic [11:0] IDX_STATUS       = 12'h0c1;
  localparam logic [11:0] IDX_EVENT_COUNT  = 12'h0c2;
  localparam logic [11:0] ADDR_INIT_CTRL    = 12'(IDX_INIT_CTRL * 4);
  localparam logic [11:0] ADDR_REFRESH_CTRL = 12'(IDX_REFRESH_CTRL * 4);
  localparam logic [11:0] ADDR_STATUS       = 12'(IDX_STATUS * 4);
  localparam logic [11:0] ADDR_EVENT_COUNT  = 12'(IDX_EVENT_COUNT * 4);

  // Field positions in the memory interface init control register.
  localparam int          INIT_DONE_BIT    = 27;
  localparam int          DEV_PRESENT_BIT  = 24;

  // Field positions of the four pair selects in the refresh register.
  localparam int          PAIR0_LSB        = 0;
  localparam int          PAIR1_LSB        = 2;
  localparam int          PAIR2_LSB        = 4;
  localparam int          PAIR3_LSB        = 6;

  // Field positions in the status register.
  localparam int          STAT_ACTIVE_LSB  = 0;
  localparam int          STAT_RUN_BIT     = 4;
  localparam int          STAT_PRESENT_BIT = 5;

  // Values after reset.
  localparam logic [7:0]  REFRESH_RESET    = 8'h00;
  localparam logic [1:0]  INIT_RESET       = 2'h0;

  // Interval select codes.
  localparam logic [1:0]  SEL_OFF          = 2'h0;
  localparam logic [1:0]  SEL_1US95        = 2'h1;
  localparam logic [1:0]  SEL_3US9         = 2'h2;
  localparam logic [1:0]  SEL_7US8         = 2'h3;

  // Interval times and the clock period, in nanoseconds.
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          T_1US95_NS       = 1950;
  localparam int          T_3US9_NS        = 3900;
  localparam int          T_7US8_NS        = 7800;

  // All three intervals round down to whole cycles, never below one.
  localparam int          CYC_1US95 = (T_1US95_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      T_1US95_NS / CLK_PERIOD_NS;
  localparam int          CYC_3US9  = (T_3US9_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      T_3US9_NS / CLK_PERIOD_NS;
  localparam int          CYC_7US8  = (T_7US8_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      T_7US8_NS / CLK_PERIOD_NS;
  localparam int          CNT_W     = 8;

  // Bus slave phase of the APB answer.
  typedef enum logic [0:0] {ST_IDLE, ST_ANSWER} mrr_bus_e;

endpackage : mrr_pkg

// ---- core/mrr_pair_timer.sv ----
`timescale 1ns/1ps
module mrr_pair_timer
  import mrr_pkg::*;
#(
  parameter int W = CNT_W
)
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control.
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  // Refresh request pulse.
  output logic            req
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [1:0]   sel_q;
  logic [1:0]   sel_d;
  logic         req_q;
  logic         req_d;

  // Cycle count of one interval for a select code.
  function automatic logic [W-1:0] interval_cycles(input logic [1:0] s);
    case (s)
      SEL_1US95: interval_cycles = W'(CYC_1US95);
      SEL_3US9:  interval_cycles = W'(CYC_3US9);
      SEL_7US8:  interval_cycles = W'(CYC_7US8);
      default:   interval_cycles = '0;
    endcase
  endfunction : interval_cycles

  // A new select restarts the interval so no short first period appears.
  always_comb
  begin
    cnt_d = cnt_q;
    sel_d = sel;
    req_d = 1'b0;
    if (!enable || sel == SEL_OFF || sel != sel_q)
    begin
      cnt_d = interval_cycles(sel) - W'(1);
    end
    else if (cnt_q == '0)
    begin
      req_d = 1'b1;
      cnt_d = interval_cycles(sel) - W'(1);
    end
    else
    begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Registers of the interval counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      sel_q <= SEL_OFF;
      req_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      req_q <= req_d;
    end
  end

  assign req = req_q;

endmodule : mrr_pair_timer

// ---- core/mrr_refresh_ctrl.sv ----
`timescale 1ns/1ps
module mrr_refresh_ctrl
  import mrr_pkg::*;
#(
  parameter int PAIRS = NUM_PAIRS
)
(
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [APB_DW-1:0]     pwdata,
  output logic      [APB_DW-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Refresh requests toward the channel pairs.
  output logic      [PAIRS-1:0]      refresh_req,
  // Init complete level toward the memory interface.
  output logic                       refresh_running
);

  mrr_bus_e          bus_q;
  mrr_bus_e          bus_d;
  logic [APB_DW-1:0] prdata_q;
  logic [APB_DW-1:0] prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [7:0]        refresh_ctrl_q;
  logic [7:0]        refresh_ctrl_d;
  logic              init_done_q;
  logic              init_done_d;
  logic              dev_present_q;
  logic              dev_present_d;
  logic [PAIRS-1:0]  req_w;
  logic [PAIRS-1:0]  req_q;
  logic [7:0]        evt_cnt_q [PAIRS];
  logic [7:0]        evt_cnt_d [PAIRS];
  logic              wr_take;
  logic              known;
  logic [APB_DW-1:0] rd_word;

  // Select code of one pair taken from the packed refresh register.
  function automatic logic [1:0] pair_sel(input logic [7:0] r,
                                          input int         p);
    pair_sel = r[p*FIELD_W +: FIELD_W];
  endfunction : pair_sel

  // Address decoder shared by read and write paths.
  function automatic logic addr_known(input logic [APB_AW-1:0] a);
    if (a == ADDR_INIT_CTRL)
      addr_known = 1'b1;
    else if (a == ADDR_REFRESH_CTRL)
      addr_known = 1'b1;
    else if (a == ADDR_STATUS)
      addr_known = 1'b1;
    else if (a == ADDR_EVENT_COUNT)
      addr_known = 1'b1;
    else
      addr_known = 1'b0;
  endfunction : addr_known

  assign known   = addr_known(paddr);
  // A write lands only at the edge where the master sees pready high.
  assign wr_take = psel && penable && pready_q && pwrite && known;

  // Read multiplexer; unused bits read as zero.
  always_comb
  begin
    rd_word = '0;
    if (paddr == ADDR_INIT_CTRL)
    begin
      rd_word[INIT_DONE_BIT]   = init_done_q;
      rd_word[DEV_PRESENT_BIT] = dev_present_q;
    end
    else if (paddr == ADDR_REFRESH_CTRL)
    begin
      rd_word[7:0] = refresh_ctrl_q;
    end
    else if (paddr == ADDR_STATUS)
    begin
      for (int p = 0; p < PAIRS; p++)
        rd_word[STAT_ACTIVE_LSB + p] = init_done_q &&
                                       pair_sel(refresh_ctrl_q, p) != SEL_OFF;
      rd_word[STAT_RUN_BIT]     = init_done_q;
      rd_word[STAT_PRESENT_BIT] = dev_present_q;
    end
    else if (paddr == ADDR_EVENT_COUNT)
    begin
      for (int p = 0; p < PAIRS; p++)
        rd_word[p*8 +: 8] = evt_cnt_q[p];
    end
  end

  // APB answer: one wait state, then pready for a single cycle.
  always_comb
  begin
    bus_d     = bus_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    case (bus_q)
      ST_IDLE:
      begin
        if (psel && penable)
        begin
          bus_d     = ST_ANSWER;
          pready_d  = 1'b1;
          pslverr_d = !known;
          prdata_d  = pwrite ? '0 : rd_word;
        end
      end
      ST_ANSWER:
      begin
        bus_d = ST_IDLE;
      end
      default:
      begin
        bus_d = ST_IDLE;
      end
    endcase
  end

  // Registers written by software.
  always_comb
  begin
    refresh_ctrl_d = refresh_ctrl_q;
    init_done_d    = init_done_q;
    dev_present_d  = dev_present_q;
    if (wr_take && paddr == ADDR_REFRESH_CTRL)
    begin
      refresh_ctrl_d[PAIR3_LSB +: FIELD_W] =
        pwdata[PAIR3_LSB +: FIELD_W];
      refresh_ctrl_d[PAIR2_LSB +: FIELD_W] =
        pwdata[PAIR2_LSB +: FIELD_W];
      refresh_ctrl_d[PAIR1_LSB +: FIELD_W] =
        pwdata[PAIR1_LSB +: FIELD_W];
      refresh_ctrl_d[PAIR0_LSB +: FIELD_W] =
        pwdata[PAIR0_LSB +: FIELD_W];
    end
    else if (wr_take && paddr == ADDR_INIT_CTRL)
    begin
      init_done_d   = pwdata[INIT_DONE_BIT];
      dev_present_d = pwdata[DEV_PRESENT_BIT];
    end
  end

  // Count issued refreshes per pair; the counts wrap at 255.
  always_comb
  begin
    for (int p = 0; p < PAIRS; p++)
      evt_cnt_d[p] = req_w[p] ? evt_cnt_q[p] + 8'h01 : evt_cnt_q[p];
  end

  // State registers of the bus slave and the software registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_q          <= ST_IDLE;
      prdata_q       <= '0;
      pready_q       <= 1'b0;
      pslverr_q      <= 1'b0;
      refresh_ctrl_q <= REFRESH_RESET;
      init_done_q    <= INIT_RESET[1];
      dev_present_q  <= INIT_RESET[0];
      req_q          <= '0;
      for (int p = 0; p < PAIRS; p++)
        evt_cnt_q[p] <= 8'h00;
    end
    else
    begin
      bus_q          <= bus_d;
      prdata_q       <= prdata_d;
      pready_q       <= pready_d;
      pslverr_q      <= pslverr_d;
      refresh_ctrl_q <= refresh_ctrl_d;
      init_done_q    <= init_done_d;
      dev_present_q  <= dev_present_d;
      req_q          <= req_w;
      for (int p = 0; p < PAIRS; p++)
        evt_cnt_q[p] <= evt_cnt_d[p];
    end
  end

  // One interval timer per pair; each restarts when its code changes.
  for (genvar g = 0; g < PAIRS; g++)
  begin : g_pair
    mrr_pair_timer #(
      .W       (CNT_W)
    ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (init_done_q),
      .sel     (pair_sel(refresh_ctrl_q, g)),
      .req     (req_w[g])
    );
  end

  // Outputs straight from flip-flops.
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign refresh_req     = req_q;
  assign refresh_running = init_done_q;

endmodule : mrr_refresh_ctrl

// ---- test/mrr_refresh_sva.sv ----
`timescale 1ns/1ps
module mrr_refresh_sva
  import mrr_pkg::*;
(
  // Clock and reset.
  input wire logic              pclk,
  input wire logic              presetn,
  // APB side.
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Refresh side.
  input wire logic [3:0]        refresh_req,
  input wire logic              refresh_running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Phases of one bus transfer.
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  chk_ready_wait: assert property (s_setup ##1 (psel && penable)
    |-> !pready ##1 pready) else $error("pready not after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_data: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read data not zero");
  chk_map_ok: assert property (s_done && paddr == ADDR_REFRESH_CTRL
    |-> !pslverr) else $error("refresh register refused");
  chk_init_level: assert property (
    s_done && pwrite && paddr == ADDR_INIT_CTRL |=>
    refresh_running == $past(pwdata[INIT_DONE_BIT]))
    else $error("running level not init bit");
  chk_idle_quiet: assert property (
    !refresh_running && !$past(refresh_running) &&
    !$past(refresh_running, 2) |-> refresh_req == '0)
    else $error("refresh while init clear");
  chk_pulse_one: assert property (
    (refresh_req & $past(refresh_req)) == '0)
    else $error("refresh request wider than a cycle");
  chk_gap_min: assert property (
    refresh_req[0] |=> !refresh_req[0] [*8])
    else $error("refresh requests too close");
endmodule : mrr_refresh_sva

bind mrr_refresh_ctrl mrr_refresh_sva u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .refresh_req(refresh_req),
  .refresh_running(refresh_running));

// ---- test/mrr_pair_mem.sv ----
`timescale 1ns/1ps
module mrr_pair_mem
  import mrr_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests, bit n for pair n.
  input  wire logic [3:0] refresh_req,
  // Pulse counts and last spacing per pair.
  output logic     [15:0] pulses [4],
  output logic     [15:0] gap    [4]
);
  logic [15:0] cyc [4];

  // Each pair is refreshed on its own bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulses <= '{default: '0};
      gap    <= '{default: '0};
      cyc    <= '{default: '0};
    end
    else
    begin
      for (int p = 0; p < 4; p++)
      begin
        if (refresh_req[p])
        begin
          pulses[p] <= pulses[p] + 16'h1;
          gap[p]    <= cyc[p];
          cyc[p]    <= 16'h1;
        end
        else
          cyc[p] <= cyc[p] + 16'h1;
      end
    end
  end
endmodule : mrr_pair_mem

// ---- test/memory_refresh_rate_control_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) \
  begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module memory_refresh_rate_control_tb;
  import mrr_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, er, refresh_running;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [3:0]        refresh_req;
  logic [15:0]       pulses [4], gap [4], snap [4];
  int                mismatches = 0;
  int                comparisons = 0;
  localparam int     GAPS [4] = '{0, T_1US95_NS / CLK_PERIOD_NS,
                                  T_3US9_NS / CLK_PERIOD_NS,
                                  T_7US8_NS / CLK_PERIOD_NS};

  // Block under test and the memory pairs it refreshes.
  mrr_refresh_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refresh_req(refresh_req), .refresh_running(refresh_running));
  mrr_pair_mem u_mem (.pclk(pclk), .presetn(presetn),
    .refresh_req(refresh_req), .pulses(pulses), .gap(gap));

  // Clock at 20 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Pready is looked at mid-cycle, so the release edge is the sample edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task t_reset_values;
    apb(1'b0, ADDR_REFRESH_CTRL, '0);
    `CHK("refresh reset", 32'h0, rd)
    apb(1'b0, ADDR_STATUS, '0);
    `CHK("status reset", 32'h0, rd)
    apb(1'b1, 12'h000, 32'hffff_ffff);
    `CHK("unmapped write err", 1'b1, er)
    apb(1'b0, 12'h000, '0);
    `CHK("unmapped read", 33'h1_0000_0000, {er, rd})
    $display("test reset_values done");
  endtask : t_reset_values

  task t_gated;
    apb(1'b1, ADDR_INIT_CTRL, 32'h0100_0000);
    apb(1'b1, ADDR_REFRESH_CTRL, 32'h0000_00e4);
    apb(1'b0, ADDR_REFRESH_CTRL, '0);
    `CHK("refresh readback", 32'h0000_00e4, rd)
    snap = pulses;
    repeat (400) @(posedge pclk);
    for (int p = 0; p < 4; p++)
      `CHK("gated pulses", snap[p], pulses[p])
    $display("test gated done");
  endtask : t_gated

  task t_codes(input logic [7:0] val);
    logic [31:0] st;
    apb(1'b1, ADDR_REFRESH_CTRL, {24'h0, val});
    apb(1'b1, ADDR_INIT_CTRL, 32'h0900_0000);
    repeat (3) @(posedge pclk);
    snap = pulses;
    repeat (500) @(posedge pclk);
    st = 32'h30;
    for (int p = 0; p < 4; p++)
    begin
      st[p] = (val[2*p+:2] != 2'h0);
      if (val[2*p+:2] == 2'h0)
        `CHK("off pulses", snap[p], pulses[p])
      else
        `CHK("gap", 16'(GAPS[val[2*p+:2]]), gap[p])
    end
    apb(1'b0, ADDR_STATUS, '0);
    `CHK("status", st, rd)
    $display("test codes %0h done", val);
  endtask : t_codes

  task t_stop;
    apb(1'b1, ADDR_INIT_CTRL, 32'h0100_0000);
    repeat (3) @(posedge pclk);
    snap = pulses;
    repeat (400) @(posedge pclk);
    for (int p = 0; p < 4; p++)
      `CHK("stopped pulses", snap[p], pulses[p])
    apb(1'b0, ADDR_EVENT_COUNT, '0);
    `CHK("events", {pulses[3][7:0], pulses[2][7:0], pulses[1][7:0],
                    pulses[0][7:0]}, rd)
    do_reset();
    apb(1'b0, ADDR_REFRESH_CTRL, '0);
    `CHK("refresh after reset", 32'h0, rd)
    `CHK("running after reset", 1'b0, refresh_running)
    $display("test stop_and_reset done");
  endtask : t_stop

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    do_reset();
    t_reset_values();
    t_gated();
    t_codes(8'he4);
    t_codes(8'h1b);
    t_stop();
    complete_run();
  end

  // Watchdog well beyond the two thousand or so cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
endmodule : memory_refresh_rate_control_tb
